// file: include/rsp_pkg.sv
// Package of constants and types for the serial slave port of the clock.
package rsp_pkg;

  // ---------------------------------------------------------------------
  // Register map and field layout.
  // ---------------------------------------------------------------------
  localparam logic [6:0] CHG_ADDR = 7'h11;
  localparam logic [7:0] CHG_RST = 8'h00;
  localparam int CHG_PAT_LSB = 4;
  localparam int CHG_DS_LSB = 2;
  localparam int CHG_RS_LSB = 0;
  localparam logic [3:0] CHG_KEY = 4'hA;
  localparam logic [1:0] DS_ONE = 2'h1;
  localparam logic [1:0] DS_TWO = 2'h2;
  localparam logic [1:0] RS_NONE = 2'h0;
  localparam int DIR_BIT = 7;

  // ---------------------------------------------------------------------
  // Address wrap points for burst transfers.
  // ---------------------------------------------------------------------
  localparam logic [6:0] RAM_LAST = 7'h7F;
  localparam logic [6:0] RAM_FIRST = 7'h20;

  // ---------------------------------------------------------------------
  // Transfer sizes and buffer shape.
  // ---------------------------------------------------------------------
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int FIFO_DEPTH = 16;

  // Transfer phase of the port.
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_READ, ST_WRITE} rsp_state_t;

  // One register write leaving the port.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } rsp_wr_t;

endpackage

// file: rtl/rsp_port.sv
// Serial slave port with charger control decode and a write buffer.
`timescale 1ns/10ps

// Small FIFO with valid and ready on both sides.
module rsp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire push = in_valid && in_ready && clk_en;
  wire pop = out_valid && out_ready && clk_en;

  // Full and empty come straight from the fill count.
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];

  // Storage array is written without reset.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

module rsp_port #(
  parameter int FIFO_DEPTH = rsp_pkg::FIFO_DEPTH
) (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Serial pins.
  input wire logic chip_enable,
  input wire logic sclk,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic interface_select_pin,
  // Supply status.
  input wire logic battery_backed,
  input wire logic primary_below_battery,
  // Read access to the registers outside.
  output logic [7:0] rd_addr,
  output logic rd_req,
  input wire logic [7:0] rd_data,
  // Write stream to the registers outside.
  output logic wr_valid,
  input wire logic wr_ready,
  output rsp_pkg::rsp_wr_t wr_word,
  output logic wr_overflow,
  // Charger controls.
  output logic charge_enable,
  output logic diode_one,
  output logic diode_two,
  output logic [2:0] resistor_onehot
);
  // -----------------------------------------------------------------------
  // Input synchronisers and edge detection.
  // -----------------------------------------------------------------------
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic ce_d_r;
  logic sclk_d_r;
  wire ce_s = sync2_r[0];
  wire sclk_s = sync2_r[1];
  wire din_s = sync2_r[2];
  wire spi_mode = sync2_r[3];
  wire bb_s = sync2_r[4];
  wire low_s = sync2_r[5];

  // Every pin passes two flops before any logic reads it.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      ce_d_r <= 1'b0;
      sclk_d_r <= 1'b0;
    end else if (clk_en) begin
      sync1_r <= {primary_below_battery, battery_backed, interface_select_pin, serial_in, sclk, chip_enable};
      sync2_r <= sync1_r;
      ce_d_r <= ce_s;
      sclk_d_r <= sclk_s;
    end
  end

  // -----------------------------------------------------------------------
  // Transfer state.
  // -----------------------------------------------------------------------
  rsp_pkg::rsp_state_t state_r;
  logic idle_pol_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shin_r;
  logic [7:0] tx_r;
  logic [7:0] addr_r;
  logic load_pend_r;
  logic out_r;
  logic oe_r;
  logic ovf_r;
  logic [7:0] chg_r;

  // Edge decode: in SPI mode strobe returns the clock to idle and shift leaves idle; in three-wire mode strobe is the rising edge.
  wire ce_rise = ce_s && !ce_d_r;
  wire sclk_edge = (sclk_s != sclk_d_r);
  wire strobe = ce_s && sclk_edge && (spi_mode ? (sclk_s == idle_pol_r) : sclk_s);
  wire shift = ce_s && sclk_edge && !strobe;
  wire [7:0] shin_nxt = spi_mode ? {shin_r[6:0], din_s} : {din_s, shin_r[7:1]};
  wire byte_done = strobe && (bit_cnt_r == rsp_pkg::LAST_BIT);
  wire protect = bb_s && low_s;
  wire is_chg = (addr_r[6:0] == rsp_pkg::CHG_ADDR);
  wire wr_byte = byte_done && (state_r == rsp_pkg::ST_WRITE) && !protect;
  wire chg_we = wr_byte && is_chg;
  wire fifo_in_ready;
  wire push = wr_byte && !is_chg && fifo_in_ready;
  wire [6:0] ram_inc = (addr_r[6:0] == rsp_pkg::RAM_LAST) ? rsp_pkg::RAM_FIRST : addr_r[6:0] + 7'h01;
  wire [7:0] addr_inc = (addr_r[6:5] == 2'h0) ? {addr_r[7:5], addr_r[4:0] + 5'h01} : {addr_r[7], ram_inc};
  wire [7:0] rd_val = is_chg ? chg_r : rd_data;
  wire [7:0] tx_nxt = spi_mode ? {tx_r[6:0], 1'b0} : {1'b0, tx_r[7:1]};

  // Transfer sequencer; chip enable low clears all its state except the sampled idle polarity.
  always_ff @(posedge clk_sys) begin
    if (rst || (clk_en && !ce_s)) begin
      state_r <= rsp_pkg::ST_IDLE;
      bit_cnt_r <= '0;
      shin_r <= '0;
      tx_r <= '0;
      addr_r <= '0;
      load_pend_r <= 1'b0;
      out_r <= 1'b0;
      oe_r <= 1'b0;
      idle_pol_r <= rst ? 1'b0 : idle_pol_r;
    end else if (clk_en) begin
      load_pend_r <= 1'b0;
      if (ce_rise) begin
        idle_pol_r <= sclk_s;
        state_r <= rsp_pkg::ST_ADDR;
      end
      if (strobe) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        shin_r <= shin_nxt;
      end
      if (byte_done && state_r == rsp_pkg::ST_ADDR) begin
        addr_r <= shin_nxt;
        state_r <= shin_nxt[rsp_pkg::DIR_BIT] ? rsp_pkg::ST_WRITE : rsp_pkg::ST_READ;
        load_pend_r <= !shin_nxt[rsp_pkg::DIR_BIT];
      end else if (byte_done && state_r != rsp_pkg::ST_IDLE) begin
        addr_r <= addr_inc;
        load_pend_r <= (state_r == rsp_pkg::ST_READ);
      end
      if (load_pend_r) begin
        tx_r <= rd_val;
      end else if (shift && state_r == rsp_pkg::ST_READ) begin
        oe_r <= 1'b1;
        out_r <= spi_mode ? tx_r[7] : tx_r[0];
        tx_r <= tx_nxt;
      end
    end
  end

  // Charger register and overflow flag survive chip enable low.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chg_r <= rsp_pkg::CHG_RST;
      ovf_r <= 1'b0;
    end else if (clk_en) begin
      if (chg_we) begin
        chg_r <= shin_nxt;
      end
      if (wr_byte && !is_chg && !fifo_in_ready) begin
        ovf_r <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Charger decode.
  // -----------------------------------------------------------------------
  wire [3:0] charge_enable_pattern = chg_r[rsp_pkg::CHG_PAT_LSB +: 4];
  wire [1:0] diode_count_select = chg_r[rsp_pkg::CHG_DS_LSB +: 2];
  wire [1:0] resistor_select = chg_r[rsp_pkg::CHG_RS_LSB +: 2];
  wire ds_ok = (diode_count_select == rsp_pkg::DS_ONE) || (diode_count_select == rsp_pkg::DS_TWO);

  // Charger enable needs the key, a valid diode code and a resistor.
  assign charge_enable = (charge_enable_pattern == rsp_pkg::CHG_KEY) && ds_ok &&
                         (resistor_select != rsp_pkg::RS_NONE);
  assign diode_one = charge_enable && (diode_count_select == rsp_pkg::DS_ONE);
  assign diode_two = charge_enable && (diode_count_select == rsp_pkg::DS_TWO);
  // The shift stays four bits wide until after the halving, so code 11 keeps its bit.
  assign resistor_onehot = charge_enable ? 3'((4'h1 << resistor_select) >> 1) : 3'h0;

  // -----------------------------------------------------------------------
  // Outputs and write buffer.
  // -----------------------------------------------------------------------
  assign serial_out = out_r;
  assign serial_out_oe = oe_r;
  assign rd_addr = addr_r;
  assign rd_req = load_pend_r;
  assign wr_overflow = ovf_r;

  rsp_fifo #(
    .WIDTH($bits(rsp_pkg::rsp_wr_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({addr_r, shin_nxt}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_word)
  );

  // -----------------------------------------------------------------------
  // Assertions.
  // -----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence ce_rise_s;
    clk_en && ce_rise;
  endsequence
  sequence ce_low_s;
    clk_en && !ce_s;
  endsequence

  chg_key_a: assert property (charge_enable |-> chg_r[7:4] == 4'hA) else $error("charger on without key");
  chg_reset_a: assert property ($past(rst) |-> !charge_enable && chg_r == 8'h00)
    else $error("charger not off after reset");
  diode_sel_a: assert property (charge_enable |-> (diode_one ^ diode_two) &&
    diode_one == (chg_r[3:2] == 2'h1))
    else $error("diode select wrong");
  diode_off_a: assert property (chg_r[3] == chg_r[2] |-> !charge_enable) else $error("bad diode code enables");
  res_sel_a: assert property (charge_enable |-> $onehot(resistor_onehot) &&
    resistor_onehot == {chg_r[1:0] == 2'h3, chg_r[1:0] == 2'h2, chg_r[1:0] == 2'h1})
    else $error("resistor select wrong");
  res_off_a: assert property (chg_r[1:0] == 2'h0 |-> !charge_enable && resistor_onehot == 3'h0)
    else $error("no resistor enables");
  wr_block_a: assert property (bb_s && low_s |=> $stable(chg_r) && !$past(push))
    else $error("write while protected");
  pol_take_a: assert property (ce_rise_s |=> idle_pol_r == $past(sclk_s)) else $error("polarity not sampled");
  ce_idle_a: assert property (ce_low_s |=> !serial_out_oe && state_r == rsp_pkg::ST_IDLE && bit_cnt_r == 3'h0)
    else $error("port active while deselected");
  write_hiz_a: assert property (state_r == rsp_pkg::ST_WRITE |-> !serial_out_oe) else $error("output on in write");
  addr_wrap_a: assert property (clk_en && byte_done && state_r == rsp_pkg::ST_WRITE && addr_r == 8'h9F
    |=> addr_r == 8'h80) else $error("write wrap wrong");
  dir_pick_a: assert property (clk_en && byte_done && state_r == rsp_pkg::ST_ADDR
    |=> state_r == (shin_r[7] ? rsp_pkg::ST_WRITE : rsp_pkg::ST_READ)) else $error("direction wrong");
endmodule

// file: tb/rsp_master.sv
// Behavioural serial master that frames transfers for the port.
`timescale 1ns/10ps
module rsp_master (
  // Pacing clock.
  input wire logic clk_sys,
  // Serial pins.
  output logic chip_enable,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  logic spi = 1'b1;
  logic pol = 1'b0;

  // Pins rest deselected with the clock parked low.
  initial begin
    chip_enable = 1'b0;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // Half of the 80 ns link clock period.
  task automatic half();
    repeat (5) @(negedge clk_sys);
  endtask

  // Parks the clock at its idle level before enable rises.
  task automatic start(input logic s, input logic p);
    spi = s;
    pol = p;
    sclk = s ? p : 1'b0;
    repeat (6) @(negedge clk_sys);
    chip_enable = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask

  // One byte, one clock per bit; a released line toggles every bit.
  task automatic xbyte(input logic drv, input logic [7:0] tx, output logic [7:0] rx);
    int b;
    for (int i = 0; i < 8; i++) begin
      b = spi ? 7 - i : i;
      mosi = drv ? tx[b] : ~mosi;
      if (spi) sclk = ~pol;
      half();
      rx[b] = miso;
      sclk = spi ? pol : 1'b1;
      half();
      if (!spi) sclk = 1'b0;
    end
  endtask

  // Ends the frame and lets the line float.
  task automatic stop();
    half();
    chip_enable = 1'b0;
    mosi = ~mosi;
    repeat (6) @(negedge clk_sys);
  endtask
endmodule

// file: tb/test_rtc_serial_slave_port.sv
// Self-checking bench for the serial slave port.
`timescale 1ns/10ps
`define CHK(what, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); \
  end \
end
module test_rtc_serial_slave_port;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic spi_mode = 1'b1;
  logic bat = 1'b0;
  logic below = 1'b0;
  logic wr_ready = 1'b0;
  logic clk_en = 1'b1;
  int reqs = 0;
  logic chip_enable, sclk, mosi, line, serial_out, serial_out_oe, rd_req, wr_valid, wr_overflow;
  logic charge_enable, diode_one, diode_two;
  logic [7:0] rd_addr, r, chg, ea;
  logic [2:0] resistor_onehot;
  logic [7:0] codes [8] = '{8'hA5, 8'hAA, 8'hA7, 8'hA1, 8'hAD, 8'hA8, 8'h5A, 8'hA6};
  rsp_pkg::rsp_wr_t wr_word;
  int miscompares = 0;
  int checks_done = 0;

  // The shared line follows whoever drives it.
  assign line = serial_out_oe ? serial_out : mosi;

  // Counts read fetch pulses, sampled away from the edge that launches them.
  always @(negedge clk_sys) begin
    if (rd_req) begin
      reqs++;
    end
  end

  // System clock of 8 ns.
  initial forever #4 clk_sys = ~clk_sys;

  rsp_master m (.clk_sys(clk_sys), .chip_enable(chip_enable), .sclk(sclk), .mosi(mosi), .miso(line));

  rsp_port DUT (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .chip_enable(chip_enable), .sclk(sclk),
    .serial_in(spi_mode ? mosi : line), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .interface_select_pin(spi_mode), .battery_backed(bat), .primary_below_battery(below),
    .rd_addr(rd_addr), .rd_req(rd_req), .rd_data(~rd_addr), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_word(wr_word), .wr_overflow(wr_overflow), .charge_enable(charge_enable), .diode_one(diode_one),
    .diode_two(diode_two), .resistor_onehot(resistor_onehot));

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Single byte write: address first, then data.
  task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
    m.start(spi_mode, p);
    m.xbyte(1'b1, a, r);
    m.xbyte(1'b1, d, r);
    m.stop();
  endtask

  // Burst read; the charger reads back its register, other places the inverted address.
  task automatic rd(input logic p, input logic [7:0] a, input int n);
    int r0;
    r0 = reqs;
    m.start(spi_mode, p);
    m.xbyte(1'b1, a, r);
    for (int k = 0; k < n; k++) begin
      m.xbyte(1'b0, 8'h00, r);
      `CHK("read data", (a[6:0] == 7'h11) ? chg : ~a, r)
      a = (a == 8'h1F) ? 8'h00 : (a == 8'h7F) ? 8'h20 : a + 8'h01;
    end
    m.stop();
    `CHK("read requests", n + 1, reqs - r0)
  endtask

  // Charger outputs against the decode of the register value.
  task automatic check_chg(input logic [7:0] v);
    logic en;
    en = v[7:4] == 4'hA && (v[3:2] == 2'h1 || v[3:2] == 2'h2) && v[1:0] != 2'h0;
    `CHK("charge enable", en, charge_enable)
    `CHK("diode one", en && v[3:2] == 2'h1, diode_one)
    `CHK("diode two", en && v[3:2] == 2'h2, diode_two)
    `CHK("resistor", en ? 3'h1 << (v[1:0] - 2'h1) : 3'h0, resistor_onehot)
  endtask

  // Hang guard.
  initial begin
    #400000;
    miscompares++;
    finish_test();
  end

  // Test sequence.
  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    check_chg(8'h00);
    `CHK("output enable", 1'b0, serial_out_oe)
    `CHK("write valid", 1'b0, wr_valid)
    $display("test reset done");
    foreach (codes[i]) begin
      chg = codes[i];
      wr(i[0], 8'h91, chg);
      check_chg(chg);
    end
    $display("test charger codes done");
    rd(1'b1, 8'h10, 2);
    rd(1'b0, 8'h1F, 2);
    rd(1'b1, 8'h7F, 2);
    $display("test reads done");
    bat = 1'b1;
    below = 1'b1;
    wr(1'b0, 8'h91, 8'h00);
    check_chg(chg);
    bat = 1'b0;
    chg = 8'hA9;
    wr(1'b0, 8'h91, chg);
    check_chg(chg);
    below = 1'b0;
    $display("test write protect done");
    clk_en = 1'b0;
    wr(1'b0, 8'h91, 8'h00);
    check_chg(chg);
    clk_en = 1'b1;
    repeat (4) @(negedge clk_sys);
    check_chg(chg);
    $display("test clock enable done");
    spi_mode = 1'b0;
    repeat (4) @(negedge clk_sys);
    chg = 8'hAB;
    wr(1'b0, 8'h91, chg);
    check_chg(chg);
    rd(1'b0, 8'h11, 2);
    spi_mode = 1'b1;
    $display("test three wire done");
    m.start(1'b1, 1'b0);
    m.xbyte(1'b1, 8'h9E, r);
    for (int k = 0; k < 17; k++) begin
      m.xbyte(1'b1, k[7:0], r);
    end
    m.stop();
    `CHK("overflow", 1'b1, wr_overflow)
    for (int k = 0; k < 16; k++) begin
      repeat (2) @(negedge clk_sys);
      ea = (k < 2) ? 8'h9E + k[7:0] : 8'h7E + k[7:0];
      `CHK("write valid", 1'b1, wr_valid)
      `CHK("write word", {ea, k[7:0]}, wr_word)
      wr_ready = 1'b1;
      @(negedge clk_sys);
      wr_ready = 1'b0;
    end
    `CHK("write valid", 1'b0, wr_valid)
    $display("test burst write done");
    finish_test();
  end
endmodule
